// *** cps_pkg.sv ***
// package: register map, field positions, reset values and shared types of the power switch block
package cps_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  SYS_CTRL_OFS   = 8'h80;     // system control register
    localparam logic [7:0]  PWR_CTRL_OFS   = 8'h84;     // power word and go bit
    localparam logic [7:0]  PWR_STAT_OFS   = 8'h88;     // mode, busy, strap
    localparam int          CLK_OE_BIT     = 27;        // clock-output enable in system control
    localparam int          GO_BIT         = 31;        // write one starts a serial word
    localparam logic [31:0] SYS_CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] PWR_CTRL_RST   = 32'h0000_0000;

    // ------------------------------------------------------------
    // serial link timing
    // ------------------------------------------------------------
    localparam int          WORD_BITS      = 8;         // bits in one power control word
    localparam int          HALF_DIV       = 4;         // sys cycles per half link-clock period
    localparam int          LATCH_CYCLES   = 8;         // latch pulse width in sys cycles

    // ------------------------------------------------------------
    // shared types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] card_sel;                           // card signalling supply select
        logic [1:0] prog_sel;                           // programming supply select
    } cps_supply_s;

    typedef struct packed {
        logic clk_o;                                    // switch clock out
        logic clk_oe;                                   // switch clock drive enable
        logic data_o;                                   // data / parallel pin 2
        logic latch_o;                                  // latch / parallel pin 3
        logic pin0_o;                                   // parallel pin 0 (shared with strap)
        logic pin0_oe;                                  // parallel pin 0 enable
    } cps_pins_s;

endpackage

// *** cps_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module cps_sync #(
    parameter int W = 1                                 // number of bits
) (
    input  wire logic         clk_sys_in,               // system clock
    input  wire logic         rst_b_in,                 // sync reset, active low
    input  wire logic [W-1:0] async_in,                 // pin level
    output logic      [W-1:0] sync_out                  // synchronised level
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first flop feeds only the second
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule

// *** cps_shifter.sv ***
// serial shifter: sends a power word on data, then pulses latch
`timescale 1ns/1ns
module cps_shifter #(
    parameter int BITS = cps_pkg::WORD_BITS             // word length
) (
    input  wire logic            clk_sys_in,            // system clock
    input  wire logic            rst_b_in,              // sync reset, active low
    input  wire logic            start_in,              // one-cycle start pulse
    input  wire logic [BITS-1:0] word_in,               // word to send, msb first
    input  wire logic            rise_in,               // link clock rising edge pulse
    input  wire logic            fall_in,               // link clock falling edge pulse
    output logic                 data_out,              // serial data
    output logic                 latch_out,             // latch strobe
    output logic                 busy_out               // word in flight
);
    typedef enum logic [1:0] {CPS_IDLE, CPS_SHIFT, CPS_LATCH} cps_state_e;
    cps_state_e        st_q;
    logic [BITS-1:0]   sh_q;
    logic [7:0]        cnt_q;

    // data changes only on the falling edge, so it is steady at the rising edge
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            st_q      <= CPS_IDLE;
            sh_q      <= '0;
            cnt_q     <= 8'h00;
            data_out  <= 1'b0;
            latch_out <= 1'b0;
        end else begin
            unique case (st_q)
                CPS_IDLE: begin
                    if (start_in) begin
                        sh_q  <= word_in;
                        cnt_q <= 8'h00;
                        st_q  <= CPS_SHIFT;
                    end
                end
                CPS_SHIFT: begin
                    if (fall_in) begin
                        if (cnt_q == 8'(BITS)) begin
                            st_q      <= CPS_LATCH;   // whole word sent
                            cnt_q     <= 8'h00;
                            latch_out <= 1'b1;
                        end else begin
                            data_out <= sh_q[BITS-1]; // one bit per clock
                            sh_q     <= {sh_q[BITS-2:0], 1'b0};
                            cnt_q    <= cnt_q + 8'h01;
                        end
                    end
                end
                CPS_LATCH: begin
                    // data line frozen while latched
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(cps_pkg::LATCH_CYCLES - 1)) begin
                        latch_out <= 1'b0;
                        st_q      <= CPS_IDLE;
                    end
                end
                default: st_q <= CPS_IDLE;
            endcase
        end
    end
    assign busy_out = (st_q != CPS_IDLE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    data_at_rise_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        rise_in && st_q == CPS_SHIFT |-> $stable(data_out))
        else $error("data moved at link clock rise");
    data_in_latch_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        latch_out |=> latch_out ? $stable(data_out) : 1'b1)
        else $error("data moved during latch");
    latch_width_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $rose(latch_out) |-> latch_out [*8] ##1 !latch_out)
        else $error("latch pulse width wrong");
    word_cover_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $fell(latch_out));
endmodule

// *** cps_top.sv ***
// top: power switch interface with apb registers, serial and parallel drive, reset handling
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns

module cps_top (
    input  wire logic        clk_sys_in,                // 250 MHz bus clock
    input  wire logic        rst_b_in,                  // sync reset, active low
    input  wire logic        global_reset_n_in,         // global reset pin, active low
    input  wire logic        host_bus_reset_n_in,       // host bus reset pin, active low
    input  wire logic        suspend_n_in,              // suspend pin, active low
    input  wire logic        psel_in,                   // apb select
    input  wire logic        penable_in,                // apb enable
    input  wire logic        pwrite_in,                 // apb direction
    input  wire logic [7:0]  paddr_in,                  // apb byte address
    input  wire logic [31:0] pwdata_in,                 // apb write data
    output logic      [31:0] prdata_out,                // apb read data
    output logic             pready_out,                // apb ready
    output logic             pslverr_out,               // apb error on unmapped
    input  wire logic        switch_clock_in,           // clock pin level
    output logic             switch_clock_out,          // clock pin drive
    output logic             switch_clock_oe_out,       // clock pin drive enable
    input  wire logic        strap_in,                  // mode strap pin level
    output logic             parallel_select_pin_0_out, // strap pin drive, parallel mode
    output logic             parallel_select_pin_0_oe_out, // strap pin enable
    output logic             data_out,                  // data / parallel pin 2
    output logic             data_oe_out,               // data pin enable
    output logic             latch_out,                 // latch / parallel pin 3
    output logic             latch_oe_out               // latch pin enable
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // strap and clock pin pass the same two flops as the reset pins
    logic [4:0] pins_s;
    cps_sync #(.W(5)) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .async_in   ({global_reset_n_in, host_bus_reset_n_in, suspend_n_in,
                      switch_clock_in, strap_in}),
        .sync_out   (pins_s)
    );
    logic global_reset_n_n;
    logic host_bus_reset_n_n;
    logic susp_n;
    logic lclk_s;
    logic strap_s;
    assign {global_reset_n_n, host_bus_reset_n_n, susp_n, lclk_s, strap_s} = pins_s;

    // resets that clear registers: suspend shields both
    logic clr_all;
    logic clr_part;
    logic float_all;
    assign clr_all   = !global_reset_n_n && susp_n;
    assign clr_part  = !host_bus_reset_n_n && susp_n;
    assign float_all = !global_reset_n_n || !host_bus_reset_n_n;

    // ------------------------------------------------------------
    // strap capture and mode
    // ------------------------------------------------------------
    // strap followed while any reset pin is held and the pin floats; last sample kept on release
    logic serial_mode_q;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            serial_mode_q <= 1'b1;
        end else if (float_all) begin
            serial_mode_q <= strap_s;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0]           sys_ctrl_q;
    cps_pkg::cps_supply_s  supply_q;
    logic                  go_q;
    logic                  wr_en;
    logic                  busy;

    // apb: one wait-free access phase, sampled on clock rise
    assign wr_en = psel_in && penable_in && pwrite_in;

    // system control only falls to the global reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in || clr_all) begin
            sys_ctrl_q <= cps_pkg::SYS_CTRL_RST;
        end else if (wr_en && paddr_in == cps_pkg::SYS_CTRL_OFS) begin
            sys_ctrl_q <= pwdata_in;
        end
    end

    // power word is host-side state: either reset clears it
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in || clr_all || clr_part) begin
            supply_q <= '0;
            go_q     <= 1'b0;
        end else begin
            go_q <= 1'b0;
            // a go that arrives while a word is in flight is dropped, not queued
            if (wr_en && paddr_in == cps_pkg::PWR_CTRL_OFS) begin
                supply_q <= pwdata_in[3:0];
                go_q     <= pwdata_in[cps_pkg::GO_BIT] && !busy;    // ignored while busy
            end
        end
    end

    // read mux; unmapped answers zero with slverr
    // read data is fixed in the setup cycle, so the access phase needs no wait
    logic mapped;
    assign mapped = paddr_in == cps_pkg::SYS_CTRL_OFS || paddr_in == cps_pkg::PWR_CTRL_OFS
                 || paddr_in == cps_pkg::PWR_STAT_OFS;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in) begin
            unique case (paddr_in)
                cps_pkg::SYS_CTRL_OFS: prdata_out <= sys_ctrl_q;
                cps_pkg::PWR_CTRL_OFS: prdata_out <= {28'h000_0000, supply_q};
                cps_pkg::PWR_STAT_OFS: prdata_out <= {29'h0000_0000, strap_s, busy,
                                                      serial_mode_q};
                default:               prdata_out <= 32'h0000_0000;
            endcase
        end
    end
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    // ------------------------------------------------------------
    // link clock: own divider when driving, else edges of the pin
    // ------------------------------------------------------------
    logic       clk_drive;
    logic       lclk_prev_q;
    logic       div_clk_q;
    logic [3:0] div_q;
    // divider runs free, enabled or not: the switch acts only on a latch, and a
    // running clock spares a start-up wait before the first bit
    assign clk_drive = sys_ctrl_q[cps_pkg::CLK_OE_BIT] && serial_mode_q;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            div_q     <= 4'h0;
            div_clk_q <= 1'b0;
        end else if (div_q == 4'(cps_pkg::HALF_DIV - 1)) begin
            div_q     <= 4'h0;
            div_clk_q <= !div_clk_q;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // edge finder on the second sync flop only
    // previous level resets low, the idle level of the pin, so no false edge
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            lclk_prev_q <= 1'b0;
        end else begin
            lclk_prev_q <= lclk_s;
        end
    end
    logic rise;
    logic fall;
    logic div_tick;
    assign div_tick = div_q == 4'(cps_pkg::HALF_DIV - 1);
    assign rise = clk_drive ? (div_tick && !div_clk_q) : (lclk_s && !lclk_prev_q);
    assign fall = clk_drive ? (div_tick && div_clk_q) : (!lclk_s && lclk_prev_q);

    // ------------------------------------------------------------
    // serial shifter
    // ------------------------------------------------------------
    logic ser_data;
    logic ser_latch;
    cps_shifter #(.BITS(cps_pkg::WORD_BITS)) u_shift (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in && !clr_all && !clr_part),
        .start_in   (go_q && serial_mode_q),
        .word_in    ({4'h0, supply_q}),
        .rise_in    (rise),
        .fall_in    (fall),
        .data_out   (ser_data),
        .latch_out  (ser_latch),
        .busy_out   (busy)
    );

    // ------------------------------------------------------------
    // pin drive: mode mux and float under reset
    // ------------------------------------------------------------
    // parallel mode reuses the serial pins; the mode only changes under reset
    cps_pkg::cps_pins_s pins_d;
    always_comb begin
        pins_d = '0;
        if (serial_mode_q) begin
            pins_d.clk_o   = div_clk_q;
            pins_d.clk_oe  = clk_drive;
            pins_d.data_o  = ser_data;
            pins_d.latch_o = ser_latch;
        end else begin
            // pin1 card sel0, pin0 card sel1, pin3 prog sel0, pin2 prog sel1
            pins_d.clk_o   = supply_q.card_sel[0];
            pins_d.clk_oe  = 1'b1;
            pins_d.pin0_o  = supply_q.card_sel[1];
            pins_d.pin0_oe = 1'b1;
            pins_d.latch_o = supply_q.prog_sel[0];
            pins_d.data_o  = supply_q.prog_sel[1];
        end
    end

    // enables drop one cycle after a pin reset is seen; levels are not forced and still follow pins_d
    logic oe_q;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= !float_all;
        end
    end

    // clock and strap-shared pins are registered so they cannot glitch when driven
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            switch_clock_out          <= 1'b0;
            parallel_select_pin_0_out <= 1'b0;
        end else begin
            switch_clock_out          <= pins_d.clk_o;
            parallel_select_pin_0_out <= pins_d.pin0_o;
        end
    end
    assign data_out                     = pins_d.data_o;            // already registered
    assign latch_out                    = pins_d.latch_o;
    assign switch_clock_oe_out          = oe_q && pins_d.clk_oe;
    assign parallel_select_pin_0_oe_out = oe_q && pins_d.pin0_oe;
    assign data_oe_out                  = oe_q;
    assign latch_oe_out                 = oe_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    clk_input_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        serial_mode_q && !sys_ctrl_q[cps_pkg::CLK_OE_BIT] |-> !switch_clock_oe_out)
        else $error("clock pin driven without enable");
    float_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        float_all |=> !data_oe_out && !latch_oe_out && !switch_clock_oe_out)
        else $error("outputs driven during reset");
    float_host_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !host_bus_reset_n_n |=> !parallel_select_pin_0_oe_out)
        else $error("strap pin driven during host reset");
    keep_suspend_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !susp_n && !wr_en |=> $stable(sys_ctrl_q) && $stable(supply_q))
        else $error("registers lost in suspend");
    host_partial_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clr_part && !clr_all && !wr_en |=> $stable(sys_ctrl_q))
        else $error("host reset cleared system control");
    global_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clr_all |=> sys_ctrl_q == cps_pkg::SYS_CTRL_RST && supply_q == '0)
        else $error("global reset did not clear");
    par_drive_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !serial_mode_q && oe_q |-> (data_out == supply_q.prog_sel[1]
                                 && latch_out == supply_q.prog_sel[0])
        ##1 (switch_clock_out == $past(supply_q.card_sel[0])
          && parallel_select_pin_0_out == $past(supply_q.card_sel[1])))
        else $error("parallel select mismatch");
    apb_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        wr_en && paddr_in == cps_pkg::SYS_CTRL_OFS && !clr_all
        |=> sys_ctrl_q == $past(pwdata_in))
        else $error("system control write lost");

    // ------------------------------------------------------------
    // reset release, strap, clock drive and power write checks
    // ------------------------------------------------------------
    oe_return_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !float_all |=> data_oe_out && latch_oe_out)
        else $error("outputs not back after reset release");
    strap_mode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        float_all |=> serial_mode_q == $past(strap_s))
        else $error("strap not captured under reset");
    clk_oe_drive_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        oe_q && clk_drive |-> switch_clock_oe_out)
        else $error("clock pin not driven when enabled");
    power_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        wr_en && paddr_in == cps_pkg::PWR_CTRL_OFS && !clr_all && !clr_part
        |=> supply_q == $past(pwdata_in[3:0]))
        else $error("power word write lost");

    serial_word_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        serial_mode_q && $fell(busy));
    parallel_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !serial_mode_q && oe_q && supply_q != '0);
    suspend_keep_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !susp_n && !global_reset_n_n && sys_ctrl_q != '0);
    clk_drive_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        switch_clock_oe_out && serial_mode_q);
endmodule

// *** cps_switch_model.sv ***
// partner model: power switch that shifts on clock rise and takes the word on latch
`timescale 1ns/1ns
module cps_switch_model (
    input  wire logic       run_in,     // let the link clock run
    input  wire logic       clk_w_in,   // clock wire level
    input  wire logic       data_w_in,  // data wire level
    input  wire logic       latch_w_in, // latch wire level
    output logic            lclk_out,   // link clock made by the switch side
    output logic      [7:0] word_out,   // last latched word
    output int              cnt_out,    // number of latch strobes seen
    output int              bad_out     // data moves while latched
);
    logic [7:0] sh_q = 8'h00;
    // --------
    // link clock
    // --------
    // 32 ns, off the bus clock phase, still outside frames
    initial begin
        lclk_out = 1'b0;
        #5;
        forever #16 lclk_out = run_in ? ~lclk_out : 1'b0;
    end
    // bits are taken at the clock rise only
    always @(posedge clk_w_in) sh_q <= {sh_q[6:0], data_w_in};
    // latch applies the last eight bits shifted
    logic [7:0] word_q = 8'h00;
    int         cnt_q  = 0;
    int         bad_q  = 0;
    always @(posedge latch_w_in) begin
        word_q <= sh_q;
        cnt_q  <= cnt_q + 1;
    end
    // a moving data line while latched would upset the switch
    always @(data_w_in) if (latch_w_in) bad_q = bad_q + 1;
    assign word_out = word_q;
    assign cnt_out  = cnt_q;
    assign bad_out  = bad_q;
endmodule

// *** test_cps_top.sv ***
// testbench: apb registers, serial frames, parallel pins and pin reset cases
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH %0t got %h want %h", $time, a, e); end end
module test_cps_top;
    logic        clk_sys_in = 1'b0;
    logic        rst_b_in   = 1'b0;
    logic [2:0]  pins_q     = 3'b001;  // global, host, suspend, active low; boot asserts both
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, strap_q = 1'b1, run = 1'b0;
    logic        dl_q = 1'b0, ll_q = 1'b0, err;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata_out;
    logic        pready_out, pslverr_out, sck_o, sck_oe, p0_o, p0_oe, dat_o, dat_oe, lat_o, lat_oe;
    logic        lclk;
    logic [7:0]  word;
    int          cnt, bad, failures = 0, checks_done = 0, n, b0, c0;
    // released data and latch lines show the inverse of their last driven level
    wire         clk_w   = sck_oe ? sck_o : lclk;
    wire         data_w  = dat_oe ? dat_o : ~dl_q;
    wire         latch_w = lat_oe ? lat_o : ~ll_q;
    wire         strap_w = p0_oe ? p0_o : strap_q;
    always #2 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        if (dat_oe) dl_q <= dat_o;
        if (lat_oe) ll_q <= lat_o;
    end
    cps_top dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .global_reset_n_in(pins_q[2]),
        .host_bus_reset_n_in(pins_q[1]), .suspend_n_in(pins_q[0]), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .switch_clock_in(clk_w), .switch_clock_out(sck_o), .switch_clock_oe_out(sck_oe),
        .strap_in(strap_w), .parallel_select_pin_0_out(p0_o),
        .parallel_select_pin_0_oe_out(p0_oe), .data_out(dat_o), .data_oe_out(dat_oe),
        .latch_out(lat_o), .latch_oe_out(lat_oe));
    cps_switch_model sw (.run_in(run), .clk_w_in(clk_w), .data_w_in(data_w),
        .latch_w_in(latch_w), .lclk_out(lclk), .word_out(word), .cnt_out(cnt), .bad_out(bad));
    // --------
    // tasks
    // --------
    task automatic complete_run;
        $display("failures %0d checks_done %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_in);
    endtask
    // setup then access; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        pen <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_in);
            if (pready_out === 1'b1) break;
        end
        rd = prdata_out;
        err = pslverr_out;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n == 20) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic pinrst(input logic [2:0] p);
        @(posedge clk_sys_in);
        pins_q <= p;
        cyc(6);
        `CHK({sck_oe, p0_oe, dat_oe, lat_oe}, 4'h0)
        pins_q <= 3'b111;
        cyc(8);
    endtask
    task automatic regs(input logic [31:0] s, input logic [3:0] p);
        apb(1'b0, cps_pkg::SYS_CTRL_OFS, 32'h0);
        `CHK(rd, s)
        apb(1'b0, cps_pkg::PWR_CTRL_OFS, 32'h0);
        `CHK(rd[3:0], p)
    endtask
    // one serial word; ext selects the design-driven clock
    task automatic frame(input logic [3:0] v, input logic ext);
        b0 = bad;
        c0 = cnt;
        apb(1'b1, cps_pkg::PWR_CTRL_OFS, 32'h8000_0000 | v);
        run <= ~ext;
        for (n = 0; n < 400 && cnt == c0; n++) cyc(1);
        cyc(12);
        run <= 1'b0;
        if (cnt == c0) begin
            failures++;
            complete_run();
        end
        `CHK(word, {4'h0, v})
        `CHK(bad, b0)
        apb(1'b0, cps_pkg::PWR_STAT_OFS, 32'h0);
        `CHK(rd[1], 1'b0)
    endtask
    // --------
    // main sequence
    // --------
    initial begin
        cyc(5);
        rst_b_in <= 1'b1;
        cyc(4);
        `CHK({sck_oe, p0_oe, dat_oe, lat_oe}, 4'h0)
        pins_q <= 3'b111;
        cyc(8);
        regs(cps_pkg::SYS_CTRL_RST, cps_pkg::PWR_CTRL_RST[3:0]);
        apb(1'b0, cps_pkg::PWR_STAT_OFS, 32'h0);
        `CHK(rd, 32'h0000_0005)
        apb(1'b1, 8'h90, 32'hffff_ffff);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h90, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        `CHK(sck_oe, 1'b0)
        frame(4'h9, 1'b0);
        apb(1'b1, cps_pkg::SYS_CTRL_OFS, 32'h0800_0000);
        cyc(2);
        `CHK(sck_oe, 1'b1)
        frame(4'h6, 1'b1);
        pinrst(3'b010);
        regs(32'h0800_0000, 4'h6);
        pinrst(3'b100);
        regs(32'h0800_0000, 4'h6);
        pinrst(3'b101);
        regs(32'h0800_0000, 4'h0);
        strap_q <= 1'b0;
        pinrst(3'b011);
        regs(32'h0, 4'h0);
        apb(1'b0, cps_pkg::PWR_STAT_OFS, 32'h0);
        `CHK(rd[2:0], 3'h0)
        for (int v = 0; v < 16; v++) begin
            apb(1'b1, cps_pkg::PWR_CTRL_OFS, 32'h8000_0000 | v);
            cyc(3);
            `CHK({dat_o, lat_o, p0_o, sck_o, dat_oe, lat_oe, p0_oe, sck_oe}, {v[1:0], v[3:2], 4'hf})
        end
        apb(1'b0, cps_pkg::PWR_STAT_OFS, 32'h0);
        `CHK(rd[1], 1'b0)
        complete_run();
    end
    // hang guard
    initial begin
        #400000;
        failures++;
        complete_run();
    end
endmodule
